// >>> design/lcgs_gate_select.sv
// Gate input select registers and gate source combining behind an AXI4-Lite slave
`timescale 1ns/1ns
`default_nettype none
`include "lcgs_map.svh"

module lcgs_gate_select
  import lcgs_pkg::*;
#(
  parameter int NUM_GATES = 4,
  parameter int NUM_SOURCES = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_SOURCES-1:0] data_source,
  output logic [NUM_GATES-1:0] gate_out
);

  // --------------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------------
  // Asserts at once but lets go on a clock edge, so all flops leave reset together
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_n <= 1'h0;
      rst_n <= 1'h0;
    end else begin
      rst_meta_n <= 1'h1;
      rst_n <= rst_meta_n;
    end
  end

  // --------------------------------------------------------------------------
  // Write channel: address and data latched in either order
  // --------------------------------------------------------------------------
  lcgs_select_regs_s regs;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  lcgs_resp_e bresp;

  // Both readies drop while a response waits: one write in flight at a time
  // Whichever half arrives first is parked until its partner is taken
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;

  wire logic aw_take = s_axi_awvalid && s_axi_awready;
  wire logic w_take = s_axi_wvalid && s_axi_wready;
  wire logic have_aw = aw_held || aw_take;
  wire logic have_w = w_held || w_take;
  wire logic do_write = have_aw && have_w && !bvalid;
  wire logic [3:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire logic [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire logic [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire logic wr_low = (wr_addr == `LCGS_OFS_SELECT_LOW);
  wire logic wr_high = (wr_addr == `LCGS_OFS_SELECT_HIGH);

  wire logic wr_hit = wr_low || wr_high;
  // Unmapped offsets store nothing and answer with an error
  wire lcgs_resp_e wr_resp = wr_hit ? LCGS_RESP_OKAY : LCGS_RESP_SLVERR;
  wire logic low_we = do_write && wr_low;
  wire logic high_we = do_write && wr_high;

  // Byte lanes above the 16-bit registers are ignored
  function automatic lcgs_select_t merge(lcgs_select_t old, logic [31:0] d, logic [3:0] s);
    merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  wire lcgs_select_t next_low = merge(regs.low, wr_data, wr_strb);
  wire lcgs_select_t next_high = merge(regs.high, wr_data, wr_strb);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'h0;
      w_held <= 1'h0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      if (do_write) begin
        aw_held <= 1'h0;
        w_held <= 1'h0;
      end else begin
        if (aw_take) begin
          aw_held <= 1'h1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'h1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Select registers
  // --------------------------------------------------------------------------
  // Partial strobes keep the other byte, so one gate can be changed alone
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs.low <= `LCGS_RST_SELECT_LOW;
      regs.high <= `LCGS_RST_SELECT_HIGH;
    end else begin
      if (low_we) begin
        regs.low <= next_low;
      end
      if (high_we) begin
        regs.high <= next_high;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Write response
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid <= 1'h0;
      bresp <= LCGS_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'h1;
      bresp <= wr_resp;
    end else if (s_axi_bready) begin
      bvalid <= 1'h0;
    end
  end

  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;

  // --------------------------------------------------------------------------
  // Read channel
  // --------------------------------------------------------------------------
  logic rvalid;
  logic [31:0] rdata;
  lcgs_resp_e rresp;

  // A new address waits until the previous data has been taken
  assign s_axi_arready = !rvalid;
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic rd_low = (s_axi_araddr == `LCGS_OFS_SELECT_LOW);
  wire logic rd_high = (s_axi_araddr == `LCGS_OFS_SELECT_HIGH);
  wire logic rd_hit = rd_low || rd_high;

  // Upper half reads zero: the select registers are only 16 bits wide
  wire lcgs_select_t rd_reg = rd_low ? regs.low : (rd_high ? regs.high : 16'h0000);
  wire logic [31:0] rd_word = {16'h0000, rd_reg};
  wire lcgs_resp_e rd_resp = rd_hit ? LCGS_RESP_OKAY : LCGS_RESP_SLVERR;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid <= 1'h0;
      rdata <= 32'h0000_0000;
      rresp <= LCGS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid <= 1'h1;
      rdata <= rd_word;
      rresp <= rd_resp;
    end else if (s_axi_rready) begin
      rvalid <= 1'h0;
    end
  end

  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  // --------------------------------------------------------------------------
  // Gate combining
  // --------------------------------------------------------------------------
  // Gates 1 and 2 live in the low register, gates 3 and 4 in the high one
  wire logic [31:0] gate_bytes = {regs.high, regs.low};
  logic [NUM_GATES-1:0] next_gate;

  // Source s owns bit 2s (negated) and bit 2s+1 (true) of its gate's byte
  genvar g;
  genvar s;
  generate
    for (g = 0; g < NUM_GATES; g++) begin : g_gate
      wire logic [NUM_SOURCES-1:0] true_hit;
      wire logic [NUM_SOURCES-1:0] neg_hit;
      for (s = 0; s < NUM_SOURCES; s++) begin : g_src
        localparam int BASE = g * `LCGS_GATE_BYTE_WIDTH + 2 * s;
        assign true_hit[s] = gate_bytes[BASE + `LCGS_TRUE_BIT] && data_source[s];
        assign neg_hit[s] = gate_bytes[BASE + `LCGS_NEG_BIT] && !data_source[s];
      end
      // No enabled input leaves the OR at zero
      assign next_gate[g] = |true_hit || |neg_hit;
    end
  endgenerate

  // Registered so the gate outputs never glitch on a register write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      gate_out <= '0;
    end else begin
      gate_out <= next_gate;
    end
  end

endmodule // lcgs_gate_select
`default_nettype wire

// >>> design/lcgs_map.svh
// Register map, field positions and reset values of the gate input select block
`ifndef LCGS_MAP_SVH
`define LCGS_MAP_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define LCGS_OFS_SELECT_LOW 4'h0
`define LCGS_OFS_SELECT_HIGH 4'h4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LCGS_RST_SELECT_LOW 16'h0000
`define LCGS_RST_SELECT_HIGH 16'h0000

// ----------------------------------------------------------------------------
// Field layout: gate g, source s (1..4), negated at 2*(s-1), true one above
// ----------------------------------------------------------------------------
`define LCGS_GATE_BYTE_WIDTH 8
`define LCGS_GATE1_LSB 0
`define LCGS_GATE2_LSB 8
`define LCGS_GATE3_LSB 0
`define LCGS_GATE4_LSB 8
`define LCGS_NEG_BIT 0
`define LCGS_TRUE_BIT 1

`endif

// >>> design/lcgs_pkg.sv
// Types shared by the gate input select block
`default_nettype none
package lcgs_pkg;

  typedef logic [15:0] lcgs_select_t;

  typedef struct packed {
    lcgs_select_t high;
    lcgs_select_t low;
  } lcgs_select_regs_s;

  typedef enum logic [1:0] {
    LCGS_RESP_OKAY = 2'h0,
    LCGS_RESP_SLVERR = 2'h2
  } lcgs_resp_e;

endpackage
`default_nettype wire

// >>> verif/lcgs_gate_select_monitor.sv
// Concurrent checks tying gate outputs to the written select values
`timescale 1ns/1ns
`default_nettype none
module lcgs_gate_select_monitor
  import lcgs_pkg::*;
#(
  parameter int NUM_GATES = 4,
  parameter int NUM_SOURCES = 4
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [NUM_SOURCES-1:0] data_source,
  input wire logic [NUM_GATES-1:0] gate_out
);
  // ----------------------------------------
  // Shadow select registers
  // ----------------------------------------
  // Only sees writes whose address and data are taken at one edge
  lcgs_select_t lo;
  lcgs_select_t hi;
  wire logic take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  function automatic logic pick(input logic [7:0] e, input logic [3:0] s);
    return |(e & {s[3], !s[3], s[2], !s[2], s[1], !s[1], s[0], !s[0]});
  endfunction
  wire logic [3:0] ds = data_source[3:0];
  wire logic e1 = pick(lo[7:0], ds);
  wire logic e4 = pick(hi[15:8], ds);
  wire logic e3u = pick({hi[7:4], 4'h0}, ds);
  wire logic e3l = pick({4'h0, hi[3:0]}, ds);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      {hi, lo} <= '0;
    end else if (take && s_axi_awaddr == 4'h0) begin
      lo <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : lo[15:8],
             s_axi_wstrb[0] ? s_axi_wdata[7:0] : lo[7:0]};
    end else if (take && s_axi_awaddr == 4'h4) begin
      hi <= {s_axi_wstrb[1] ? s_axi_wdata[15:8] : hi[15:8],
             s_axi_wstrb[0] ? s_axi_wdata[7:0] : hi[7:0]};
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  a_gate1_low_map: assert property (gate_out[0] == $past(e1))
    else $error("gate 1 output wrong");
  a_gate4_high_map: assert property (gate_out[3] == $past(e4))
    else $error("gate 4 output wrong");
  a_gate3_upper_pairs: assert property ($past(e3u) |-> gate_out[2])
    else $error("gate 3 misses source 4 or 3");
  a_gate3_lower_pairs: assert property ($past(e3l) |-> gate_out[2])
    else $error("gate 3 misses source 2 or 1");
  a_gate_or_zero: assert property (!$past(e3u) && !$past(e3l) |-> !gate_out[2])
    else $error("gate 3 high with nothing enabled");
  a_true_enable_pass: assert property ($past(hi[9]) && $past(ds[0]) |-> gate_out[3])
    else $error("true source not passed");
  a_neg_enable_pass: assert property ($past(hi[8]) && !$past(ds[0]) |-> gate_out[3])
    else $error("inverted source not passed");
endmodule // lcgs_gate_select_monitor
bind lcgs_gate_select lcgs_gate_select_monitor
  #(.NUM_GATES(NUM_GATES), .NUM_SOURCES(NUM_SOURCES)) u_mon (.*);
`default_nettype wire

// >>> verif/lcgs_gate_select_tb.sv
// Self-checking testbench for the gate input select block
`timescale 1ns/1ns
`default_nettype none
module lcgs_gate_select_tb;
  import lcgs_pkg::*;
  logic mclk = '0, reset_n = '0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0, s_axi_rvalid;
  // Ready for answers at all times, so no release races between transfers
  logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0, s_axi_wstrb = 4'hf, data_source = '0;
  logic [3:0] gate_out;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  int n_mismatch = 0, total_checks = 0;
  lcgs_gate_select u_lcgs_gate_select (.*);
  initial forever #10 mclk = ~mclk;
  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0, d};
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    fork
      begin
        do @(posedge mclk); while (!s_axi_awready);
        s_axi_awvalid <= 1'h0;
      end
      begin
        do @(posedge mclk); while (!s_axi_wready);
        s_axi_wvalid <= 1'h0;
      end
    join
    do @(posedge mclk); while (!s_axi_bvalid);
    chk(s_axi_bresp, r);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do @(posedge mclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge mclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, d);
    chk(s_axi_rresp, r);
  endtask
  task automatic gate(input logic [3:0] ds, input logic [3:0] exp);
    data_source <= ds;
    repeat (2) @(posedge mclk);
    chk(gate_out, exp);
  endtask
  function automatic logic [3:0] ex(input logic [3:0] a, input logic [3:0] s, input int b);
    logic v;
    v = s[(b % 8) / 2] ^ !b[0];
    return {3'h0, v} << (a == 4'h0 ? 0 : (b < 8 ? 2 : 3));
  endfunction
  task automatic t_map(input logic [3:0] a, input int n);
    for (int b = 0; b < n; b++) begin
      wr(a, 16'h1 << b, LCGS_RESP_OKAY);
      rd(a, 32'h1 << b, LCGS_RESP_OKAY);
      for (int s = 0; s < 16; s++)
        gate(s[3:0], ex(a, s[3:0], b));
    end
    $display("map test at %h done", a);
  endtask
  task automatic t_or();
    wr(4'h4, 16'h0003, LCGS_RESP_OKAY);
    gate(4'h0, 4'h4);
    gate(4'h1, 4'h4);
    wr(4'h4, 16'h0a00, LCGS_RESP_OKAY);
    gate(4'h0, 4'h0);
    gate(4'h2, 4'h8);
    gate(4'h3, 4'h8);
    wr(4'h4, 16'h0000, LCGS_RESP_OKAY);
    gate(4'hf, 4'h0);
    $display("or test done");
  endtask
  task automatic t_strobe();
    s_axi_wstrb <= 4'h1;
    wr(4'h4, 16'habcd, LCGS_RESP_OKAY);
    rd(4'h4, 32'h0000_00cd, LCGS_RESP_OKAY);
    s_axi_wstrb <= 4'h2;
    wr(4'h4, 16'h1234, LCGS_RESP_OKAY);
    rd(4'h4, 32'h0000_12cd, LCGS_RESP_OKAY);
    gate(4'h0, 4'hc);
    gate(4'h4, 4'h4);
    s_axi_wstrb <= 4'hf;
    wr(4'h4, 16'h0000, LCGS_RESP_OKAY);
    $display("strobe test done");
  endtask
  task automatic t_unmapped();
    wr(4'h8, 16'hffff, LCGS_RESP_SLVERR);
    rd(4'h8, 32'h0, LCGS_RESP_SLVERR);
    rd(4'h0, 32'h0, LCGS_RESP_OKAY);
    rd(4'h4, 32'h0, LCGS_RESP_OKAY);
    $display("unmapped test done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic t_reset();
    repeat (16) @(posedge mclk);
    reset_n <= 1'h1;
    // Two more edges pass inside the block before its own reset lets go
    repeat (3) @(posedge mclk);
    chk(gate_out, 4'h0);
    rd(4'h0, 32'h0, LCGS_RESP_OKAY);
    rd(4'h4, 32'h0, LCGS_RESP_OKAY);
    $display("reset test done");
  endtask
  initial begin
    t_reset();
    t_map(4'h0, 5);
    wr(4'h0, 16'h0000, LCGS_RESP_OKAY);
    t_map(4'h4, 16);
    t_or();
    t_strobe();
    t_unmapped();
    end_sim();
  end
  initial begin
    #200000;
    n_mismatch++;
    end_sim();
  end
endmodule // lcgs_gate_select_tb
`default_nettype wire
